// ---- src/rap_pkg.sv ----
// Purpose: constants and carriers for the region access protection unit
// Assumes: 32-bit AHB-Lite register port, one clock
// Notes: register offsets are byte addresses of aligned words
//
// Overview of operation
// - A region is a base address plus attributes, its size a power of 2.
// - The size code picks every power of two from 32 bytes to 4 GB.
// - Each region has one execute setting that allows or forbids fetches.
// - Read/write rights are judged apart for privileged and user access.
// - Every region is cut into eight equal sub-regions by the unit.
// - Sub-region disables only count in regions of 256 bytes or more.
// - Each sub-region has its own disable bit, leaving a hole in the match.
// - Each region has an enable bit written with its other attributes.
// - Region base and attributes read back only their defined fields; base bits 4:0 and unused attribute bits read 0.
// - With protection on, a denied access in a matching region faults.
// - An option lets privileged access use the default map on no match.
// - An option chooses whether fault handler accesses are checked.
// - With protection off, nothing faults and the default map applies.
package rap_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_SELECT = 8'h08;
  localparam logic [7:0] OFS_BASE = 8'h0C;
  localparam logic [7:0] OFS_ATTR = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_MASK = 8'h18;
  localparam logic [7:0] OFS_FADDR = 8'h1C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_BGMAP_BIT = 1;
  localparam int CTRL_FHCHK_BIT = 2;
  localparam int ATTR_ON_BIT = 0;
  localparam int ATTR_SIZE_LSB = 1;
  localparam int ATTR_PERM_LSB = 8;
  localparam int ATTR_XN_BIT = 11;
  localparam int ATTR_SUB_LSB = 16;
  localparam int BASE_LSB = 5;
  localparam int STAT_W = 2;
  localparam int STAT_PERM_BIT = 0;
  localparam int STAT_NOMATCH_BIT = 1;

  // ----------------------------------------------------------------
  // Size encoding: code 0 is 32 bytes, code 27 is 4 GB
  // ----------------------------------------------------------------
  localparam logic [5:0] SIZE_LOG_MIN = 6'h05;
  localparam logic [4:0] SIZE_CODE_MAX = 5'h1B;
  localparam logic [4:0] SIZE_CODE_SUB = 5'h03;
  localparam logic [5:0] LOG_FULL = 6'h20;
  localparam logic [5:0] SUB_SHIFT = 6'h03;

  // Read/write permission codes, privileged/user
  localparam logic [2:0] PERM_NO_NO = 3'h0;
  localparam logic [2:0] PERM_RW_NO = 3'h1;
  localparam logic [2:0] PERM_RW_RO = 3'h2;
  localparam logic [2:0] PERM_RW_RW = 3'h3;
  localparam logic [2:0] PERM_RO_NO = 3'h4;
  localparam logic [2:0] priv_rw_user_ro_perm = PERM_RW_RO;
  localparam logic [2:0] PERM_RO_RO = 3'h5;

  // Access kinds
  localparam logic [1:0] KIND_FETCH = 2'h0;
  localparam logic [1:0] KIND_READ = 2'h1;
  localparam logic [1:0] KIND_WRITE = 2'h2;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [1:0] kind;
    logic priv;
    logic in_handler;
  } rap_req_t;

  typedef struct packed {
    logic done;
    logic fault;
    logic [31:0] addr;
  } rap_resp_t;

  typedef struct packed {
    logic [26:0] base;
    logic region_exec_forbidden;
    logic [2:0] perm;
    logic [7:0] subregion_off_bit;
    logic [4:0] size;
    logic region_on_flag;
  } rap_rgn_t;

endpackage : rap_pkg

// ---- src/rap_region_match.sv ----
// Purpose: match one address against one region and judge its rights
// Assumes: base already aligned by software
// Notes: purely combinational, one copy per region
`timescale 1ns/100ps
module rap_region_match
(
  input rap_pkg::rap_rgn_t rgn,
  input wire logic [31:0] addr,
  input wire logic [1:0] kind,
  input wire logic priv,
  output logic hit,
  output logic allow
);
  import rap_pkg::*;

  logic [5:0] size_log;
  logic [31:0] hi_mask;
  logic [31:0] base_full;
  logic [31:0] sub_shifted;
  logic [2:0] sub_idx;
  logic in_range;
  logic sub_usable;
  logic sub_off;
  logic p_rd, p_wr, u_rd, u_wr, rd_ok, wr_ok;

  // size code to power of two
  assign size_log = (rgn.size >= SIZE_CODE_MAX) ? LOG_FULL
                  : {1'b0, rgn.size} + SIZE_LOG_MIN;
  assign hi_mask = (size_log == LOG_FULL) ? 32'h0
                 : ~((32'h1 << size_log) - 32'h1);
  assign base_full = {rgn.base, 5'h0};
  assign in_range = ((addr ^ base_full) & hi_mask) == 32'h0;

  // top three offset bits pick the eighth
  assign sub_shifted = addr >> (size_log - SUB_SHIFT);
  assign sub_idx = sub_shifted[2:0];
  assign sub_usable = rgn.size >= SIZE_CODE_SUB;
  assign sub_off = sub_usable && rgn.subregion_off_bit[sub_idx];
  assign hit = rgn.region_on_flag && in_range && !sub_off;

  assign p_rd = rgn.perm inside {PERM_RW_NO, PERM_RW_RO, PERM_RW_RW,
                                 PERM_RO_NO, PERM_RO_RO};
  assign p_wr = rgn.perm inside {PERM_RW_NO, PERM_RW_RO, PERM_RW_RW};
  assign u_rd = rgn.perm inside {PERM_RW_RO, PERM_RW_RW, PERM_RO_RO};
  assign u_wr = rgn.perm == PERM_RW_RW;
  assign rd_ok = priv ? p_rd : u_rd;
  assign wr_ok = priv ? p_wr : u_wr;

  assign allow = (kind == KIND_FETCH) ? (rd_ok && !rgn.region_exec_forbidden)
               : (kind == KIND_WRITE) ? wr_ok : rd_ok;

endmodule : rap_region_match

// ---- src/rap_top.sv ----
// Purpose: region access protection unit with AHB-Lite registers
// Assumes: one access request per cycle, zero-wait register slave
// Notes: a fault is reported one cycle after the request is taken
//
// The placing of the registers and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
module rap_top #(
  parameter int NUM_REGIONS = 8
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input rap_pkg::rap_req_t req,
  output rap_pkg::rap_resp_t resp,
  output logic mm_fault,
  output logic irq
);
  import rap_pkg::*;

  localparam int RIDX_W = (NUM_REGIONS > 1) ? $clog2(NUM_REGIONS) : 1;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic prot_on;
  logic privileged_background_map;
  logic check_in_fault_handlers;
  logic [RIDX_W-1:0] sel;
  rap_rgn_t rgns [NUM_REGIONS];
  logic [STAT_W-1:0] status;
  logic [STAT_W-1:0] mask;
  logic [31:0] fault_addr;
  logic wr_pend;
  logic [7:0] wr_ofs;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire addr_take = ce && hsel && htrans[1] && hready;
  wire rd_take = addr_take && !hwrite;
  wire [7:0] a_ofs = haddr[7:0];
  wire wr_now = ce && wr_pend;
  wire wr_ctrl = wr_now && wr_ofs == OFS_CTRL;
  wire wr_sel = wr_now && wr_ofs == OFS_SELECT;
  wire wr_base = wr_now && wr_ofs == OFS_BASE;
  wire wr_attr = wr_now && wr_ofs == OFS_ATTR;
  wire wr_mask = wr_now && wr_ofs == OFS_MASK;
  wire rd_stat = rd_take && a_ofs == OFS_STATUS;

  assign hreadyout = ce;
  assign hresp = 1'b0;

  wire rap_rgn_t cur = rgns[sel];
  wire [31:0] base_word = {cur.base, 5'h0};
  wire [31:0] attr_word = {8'h0, cur.subregion_off_bit, 4'h0,
                           cur.region_exec_forbidden, cur.perm, 2'h0,
                           cur.size, cur.region_on_flag};
  wire [31:0] ctrl_word = {29'h0, check_in_fault_handlers,
                           privileged_background_map, prot_on};
  wire [31:0] count_word = 32'(NUM_REGIONS);
  wire [31:0] rd_mux =
      (a_ofs == OFS_CTRL) ? ctrl_word :
      (a_ofs == OFS_COUNT) ? count_word :
      (a_ofs == OFS_SELECT) ? 32'(sel) :
      (a_ofs == OFS_BASE) ? base_word :
      (a_ofs == OFS_ATTR) ? attr_word :
      (a_ofs == OFS_STATUS) ? 32'(status) :
      (a_ofs == OFS_MASK) ? 32'(mask) :
      (a_ofs == OFS_FADDR) ? fault_addr : 32'h0;

  // ----------------------------------------------------------------
  // Region matchers
  // ----------------------------------------------------------------
  logic [NUM_REGIONS-1:0] hits;
  logic [NUM_REGIONS-1:0] allows;

  for (genvar g = 0; g < NUM_REGIONS; g++)
  begin : g_rgn
    rap_region_match u_match (
      .rgn(rgns[g]),
      .addr(req.addr),
      .kind(req.kind),
      .priv(req.priv),
      .hit(hits[g]),
      .allow(allows[g])
    );
  end

  logic [RIDX_W-1:0] win;
  always_comb
  begin
    win = '0;
    for (int i = 0; i < NUM_REGIONS; i++)
      if (hits[i])
        win = RIDX_W'(i);
  end

  // ----------------------------------------------------------------
  // Access decision
  // ----------------------------------------------------------------
  wire any_hit = |hits;
  wire bypass = !prot_on || (req.in_handler && !check_in_fault_handlers);
  wire perm_fault = !bypass && any_hit && !allows[win];
  // no match faults unless privileged background
  wire nomatch_fault = !bypass && !any_hit
                    && !(req.priv && privileged_background_map);
  wire chk = ce && req.valid;
  wire next_fault = chk && (perm_fault || nomatch_fault);
  wire [STAT_W-1:0] events;
  assign events[STAT_PERM_BIT] = chk && perm_fault;
  assign events[STAT_NOMATCH_BIT] = chk && nomatch_fault;
  // Event wins over the clearing read
  wire [STAT_W-1:0] next_status = (rd_stat ? '0 : status) | events;

  assign irq = |(status & mask);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_pend <= 1'b0;
      wr_ofs <= 8'h0;
      hrdata <= 32'h0;
    end
    else if (ce)
    begin
      wr_pend <= addr_take && hwrite;
      wr_ofs <= a_ofs;
      if (rd_take)
        hrdata <= rd_mux;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prot_on <= 1'b0;
      privileged_background_map <= 1'b0;
      check_in_fault_handlers <= 1'b0;
      sel <= '0;
      mask <= '0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        prot_on <= hwdata[CTRL_ON_BIT];
        privileged_background_map <= hwdata[CTRL_BGMAP_BIT];
        check_in_fault_handlers <= hwdata[CTRL_FHCHK_BIT];
      end
      if (wr_sel)
        sel <= hwdata[RIDX_W-1:0];
      if (wr_mask)
        mask <= hwdata[STAT_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < NUM_REGIONS; i++)
        rgns[i] <= '0;
    end
    else
    begin
      if (wr_base)
        rgns[sel].base <= hwdata[31:BASE_LSB];
      if (wr_attr)
      begin
        rgns[sel].region_on_flag <= hwdata[ATTR_ON_BIT];
        rgns[sel].size <= hwdata[ATTR_SIZE_LSB +: 5];
        rgns[sel].perm <= hwdata[ATTR_PERM_LSB +: 3];
        rgns[sel].region_exec_forbidden <= hwdata[ATTR_XN_BIT];
        rgns[sel].subregion_off_bit <= hwdata[ATTR_SUB_LSB +: 8];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      status <= '0;
      fault_addr <= 32'h0;
      resp <= '0;
      mm_fault <= 1'b0;
    end
    else if (ce)
    begin
      status <= next_status;
      resp.done <= chk;
      resp.fault <= next_fault;
      resp.addr <= req.addr;
      mm_fault <= next_fault;
      if (next_fault)
        fault_addr <= req.addr;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_off_no_fault: assert property (
    @(posedge clk) disable iff (!arst_n)
    (ce && req.valid && !prot_on) |=> (!mm_fault && resp.done))
    else $error("fault raised while protection off");

  a_nomatch_fault: assert property (
    @(posedge clk) disable iff (!arst_n)
    (chk && prot_on && !req.in_handler && hits == '0
     && !(req.priv && privileged_background_map))
    |=> (mm_fault && status[STAT_NOMATCH_BIT]))
    else $error("unmatched access did not fault");

  a_handler_bypass: assert property (
    @(posedge clk) disable iff (!arst_n)
    (chk && req.in_handler && !check_in_fault_handlers) |=> !resp.fault)
    else $error("handler access checked without option");

  a_exec_forbid: assert property (
    @(posedge clk) disable iff (!arst_n)
    (chk && prot_on && !req.in_handler && any_hit
     && req.kind == KIND_FETCH && rgns[win].region_exec_forbidden)
    |=> (resp.fault && fault_addr == $past(req.addr)))
    else $error("fetch from no-execute region passed");

  a_perm_none: assert property (
    @(posedge clk) disable iff (!arst_n)
    (chk && prot_on && !req.in_handler && any_hit
     && rgns[win].perm == PERM_NO_NO) |=> status[STAT_PERM_BIT])
    else $error("no-access region allowed an access");

  a_winner_top: assert property (
    @(posedge clk) disable iff (!arst_n)
    any_hit |-> (hits[win] && (hits >> win) == 1))
    else $error("winner is not the highest hit");

  a_irq_follows: assert property (
    @(posedge clk) disable iff (!arst_n)
    (next_fault && !rd_stat && !wr_mask && (events & mask) != '0)
    |=> irq ##1 (irq || $past(rd_stat) || $past(wr_mask)))
    else $error("unmasked fault did not raise irq");

  a_attr_readback: assert property (
    @(posedge clk) disable iff (!arst_n)
    (wr_attr && !wr_sel) |=> (attr_word
      == ($past(hwdata) & 32'h00FF0F3F)))
    else $error("attribute readback differs from write");

  a_stat_clear: assert property (
    @(posedge clk) disable iff (!arst_n)
    (rd_stat && events == '0) |=> (status == '0 && !irq))
    else $error("status read did not clear");

  a_resp_addr: assert property (
    @(posedge clk) disable iff (!arst_n)
    chk |=> (resp.done && resp.addr == $past(req.addr)))
    else $error("response lost the checked address");

  a_idle_quiet: assert property (
    @(posedge clk) disable iff (!arst_n)
    (ce && !req.valid) |=> (!resp.done && !mm_fault))
    else $error("response without a request");

  a_fault_addr: assert property (
    @(posedge clk) disable iff (!arst_n)
    next_fault |=> (fault_addr == $past(req.addr)))
    else $error("fault address not captured");

  a_allow_pass: assert property (
    @(posedge clk) disable iff (!arst_n)
    (chk && !bypass && any_hit && allows[win])
    |=> (!resp.fault && !mm_fault))
    else $error("permitted access faulted");

  a_bg_priv: assert property (
    @(posedge clk) disable iff (!arst_n)
    (chk && !bypass && !any_hit && req.priv && privileged_background_map)
    |=> !mm_fault)
    else $error("privileged background access faulted");

  a_handler_chk: assert property (
    @(posedge clk) disable iff (!arst_n)
    (chk && prot_on && req.in_handler && check_in_fault_handlers
     && !any_hit && !req.priv) |=> mm_fault)
    else $error("checked handler access did not fault");

endmodule : rap_top

// ---- tb/rap_core_model.sv ----
// Purpose: core-side model issuing checked accesses
// Assumes: one access in flight at a time
// Notes: idle request inverts the last address, never repeats it
`timescale 1ns/100ps
module rap_core_model
(
  input wire logic clk,
  input rap_pkg::rap_resp_t resp,
  output rap_pkg::rap_req_t req
);
  import rap_pkg::*;

  initial req = '0;

  // Result is done, fault
  task automatic access(input logic [31:0] a, input logic [1:0] k,
    input logic pv, input logic hd, output logic [1:0] r);
    @(posedge clk);
    req <= '{1'b1, a, k, pv, hd};
    @(posedge clk);
    req <= '{1'b0, ~a, 2'h3, ~pv, ~hd};
    #1;
    r = {resp.done, resp.fault};
  endtask : access
endmodule : rap_core_model

// ---- tb/test_region_access_protection.sv ----
// Purpose: self-checking bench for the protection unit
// Assumes: zero-wait register slave, ce held high
// Notes: four regions instantiated to keep set-up short
`timescale 1ns/100ps
module test_region_access_protection;
  import rap_pkg::*;
  localparam int NR = 4;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, mm_fault, irq;
  logic [31:0] hrdata;
  rap_req_t req;
  rap_resp_t resp;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;

  always #5 clk = ~clk;

  rap_top #(.NUM_REGIONS(NR)) rap_top_inst (.clk(clk), .arst_n(arst_n),
    .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .req(req),
    .resp(resp), .mm_fault(mm_fault), .irq(irq));

  rap_core_model rap_core_model_inst (.clk(clk), .resp(resp), .req(req));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic stop_test;
    if (n_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rdat);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= w ? wd : ~wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdat = hrdata;
    hsel <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(x, e);
    chk({31'h0, hresp}, 32'h0);
  endtask : rd

  // Done must come with the fault bit on both outputs
  task automatic acc(input logic [31:0] a, input logic [1:0] k,
    input logic pv, input logic hd, input logic e);
    logic [1:0] r;
    rap_core_model_inst.access(a, k, pv, hd, r);
    chk({29'h0, r, mm_fault}, {29'h0, 1'b1, e, e});
    chk(resp.addr, a);
  endtask : acc

  function automatic logic [31:0] at(logic [4:0] sz, logic [2:0] p,
    logic xn, logic [7:0] sb, logic on);
    return {8'h00, sb, 4'h0, xn, p, 2'b00, sz, on};
  endfunction : at

  // Disabled first so no access sees half-written attributes
  task automatic set_rgn(input int i, input logic [31:0] b,
    input logic [31:0] a);
    wr(OFS_SELECT, 32'(i));
    wr(OFS_ATTR, 32'h0);
    wr(OFS_BASE, b);
    wr(OFS_ATTR, a);
  endtask : set_rgn

  function automatic logic ok(logic [2:0] p, logic [1:0] k, logic pv,
    logic xn);
    logic r;
    logic w;
    r = pv ? (p inside {PERM_RW_NO, PERM_RW_RO, PERM_RW_RW, PERM_RO_NO,
      PERM_RO_RO}) : (p inside {PERM_RW_RO, PERM_RW_RW, PERM_RO_RO});
    w = pv ? (p inside {PERM_RW_NO, PERM_RW_RO, PERM_RW_RW})
      : (p == PERM_RW_RW);
    return (k == KIND_WRITE) ? w : (r && (k == KIND_READ || !xn));
  endfunction : ok

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      n_errors++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    rd(OFS_CTRL, 32'h0);
    rd(OFS_COUNT, 32'(NR));
    rd(8'h20, 32'h0);
    acc(32'h0000_3000, KIND_WRITE, 1'b0, 1'b0, 1'b0);
    set_rgn(0, 32'h0000_1000, at(5'h07, PERM_RW_RW, 1'b0, 8'h00, 1'b1));
    wr(8'h20, 32'hFFFF_FFFF);
    rd(OFS_BASE, 32'h0000_1000);
    rd(OFS_ATTR, at(5'h07, PERM_RW_RW, 1'b0, 8'h00, 1'b1));
    wr(OFS_MASK, 32'h3);
    wr(OFS_CTRL, 32'h1);
    acc(32'h0000_3000, KIND_READ, 1'b1, 1'b0, 1'b1);
    chk({31'h0, irq}, 32'h1);
    rd(OFS_FADDR, 32'h0000_3000);
    rd(OFS_STATUS, 32'h2);
    rd(OFS_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_CTRL, 32'h3);
    acc(32'h0000_3000, KIND_READ, 1'b1, 1'b0, 1'b0);
    wr(OFS_MASK, 32'h0);
    acc(32'h0000_3000, KIND_READ, 1'b0, 1'b0, 1'b1);
    chk({31'h0, irq}, 32'h0);
    rd(OFS_STATUS, 32'h2);
    acc(32'h0000_3000, KIND_READ, 1'b0, 1'b1, 1'b0);
    wr(OFS_CTRL, 32'h7);
    acc(32'h0000_3000, KIND_READ, 1'b0, 1'b1, 1'b1);
    for (int p = 0; p < 6; p++)
      for (int x = 0; x < 2; x++)
      begin
        set_rgn(0, 32'h0000_1000, at(5'h07, 3'(p), 1'(x), 8'h00, 1'b1));
        for (int k = 0; k < 3; k++)
          for (int v = 0; v < 2; v++)
            acc(32'h0000_1FFC, 2'(k), 1'(v), 1'b0,
              !ok(3'(p), 2'(k), 1'(v), 1'(x)));
      end
    rd(OFS_STATUS, 32'h3);
    set_rgn(0, 32'h0000_1000, at(5'h07, PERM_RW_RW, 1'b0, 8'h04, 1'b1));
    acc(32'h0000_1400, KIND_READ, 1'b0, 1'b0, 1'b1);
    acc(32'h0000_13FC, KIND_READ, 1'b0, 1'b0, 1'b0);
    set_rgn(1, 32'h0000_1000, at(5'h02, PERM_NO_NO, 1'b0, 8'hFF, 1'b1));
    acc(32'h0000_1000, KIND_READ, 1'b1, 1'b0, 1'b1);
    set_rgn(1, 32'h0000_1000, at(5'h03, PERM_NO_NO, 1'b0, 8'h01, 1'b1));
    acc(32'h0000_1000, KIND_READ, 1'b1, 1'b0, 1'b0);
    acc(32'h0000_1020, KIND_READ, 1'b1, 1'b0, 1'b1);
    set_rgn(1, 32'h0000_1100, at(5'h03, PERM_RO_RO, 1'b0, 8'h02, 1'b1));
    acc(32'h0000_1100, KIND_WRITE, 1'b0, 1'b0, 1'b1);
    acc(32'h0000_1120, KIND_WRITE, 1'b0, 1'b0, 1'b0);
    wr(OFS_SELECT, 32'h1);
    wr(OFS_ATTR, at(5'h03, PERM_RO_RO, 1'b0, 8'h02, 1'b0));
    acc(32'h0000_1100, KIND_WRITE, 1'b0, 1'b0, 1'b0);
    set_rgn(2, 32'h0, at(5'h1B, PERM_RO_RO, 1'b1, 8'h00, 1'b1));
    acc(32'hFFFF_FFF0, KIND_READ, 1'b0, 1'b0, 1'b0);
    acc(32'hFFFF_FFF0, KIND_WRITE, 1'b0, 1'b0, 1'b1);
    wr(OFS_CTRL, 32'h0);
    acc(32'hFFFF_FFF0, KIND_WRITE, 1'b0, 1'b0, 1'b0);
    stop_test();
  end
endmodule : test_region_access_protection
